/* logic/asel_top.sv */
// Analog source select and trip reset logic with APB registers
// Function
// (R01) Select high: current input sets frequency
// (R02) Select low: voltage input sets frequency
// (R03) Analog only when source code is analog
// (R04) No select assigned: use sum of inputs
// (R05) Reset runs on trip reset on-off
// (R06) Driver holds trip reset twelve ms minimum
// (R07) Alarm clears within thirty ms of reset
// (R08) Reset cancels trip state
// (R09) Reset held: motor off, trip cleared
// (R10) Motor resumes after reset if running
// (R11) Stuck reset at powerup shows display error
// (R12) Release reset then key clears error
// (R13) Stop key resets only during alarm
// (R14) Trip reset terminal only normally open
// (R15) Powerup performs same reset sequence
// (R16) Remote attached: key only briefly after powerup
// (R17) Reset while running lets motor coast
// (R18) No delays: outputs off together immediately
// (R19) Delayed outputs stay one second longer
// (R20) Both functions assignable to six inputs
// (R21) Trip reset synchronised, filtered, edge started
`timescale 1ns/1ps
`include "asel_consts.svh"
module asel_top #(
  parameter int TRST_MIN_CYC = `ASEL_TRST_MIN_CYC,
  parameter int STUCK_CYC    = `ASEL_STUCK_CYC,
  parameter int OUTDLY_CYC   = `ASEL_OUTDLY_CYC,
  parameter int KEYWIN_CYC   = `ASEL_KEYWIN_CYC
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Terminals and keys
  input  wire logic [5:0]  INPUT_PINS,
  input  wire logic        STOP_KEY,
  input  wire logic        ANY_KEY,
  // Analog samples
  input  wire logic [11:0] VOLT_IN,
  input  wire logic [11:0] CURR_IN,
  // Drive outputs
  output logic             MOTOR_EN,
  output logic             COAST,
  output logic             ALARM,
  output logic [2:0]       LOGIC_OUT,
  output logic             DISPLAY_ERR,
  output logic [12:0]      FREQ_CMD
);
  ////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]  func_q [6];          // Per-terminal function codes
  logic [7:0]  src_q;               // Frequency source parameter
  logic [2:0]  dly_en_q;            // Output OFF delay nonzero flags
  logic [2:0]  out_req_q;           // Software logic output requests
  logic        trip_q;              // Trip state
  logic        run_q;               // Run command
  logic        remote_q;            // Remote operator attached
  logic        wr_trip;             // Software trip set pulse
  logic        wr;                  // Write strobe
  // Zero-wait APB; every access completes in its access phase
  assign wr      = PSEL & PENABLE & PWRITE;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok(PADDR);
  assign wr_trip = wr & (PADDR == `ASEL_OFF_CTRL) & PWDATA[`ASEL_CTRL_TRIP];

  // Mapped address check
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `ASEL_OFF_CTRL) || (a == `ASEL_OFF_FUNC) || (a == `ASEL_OFF_ANALOG) ||
              (a == `ASEL_OFF_DELAY) || (a == `ASEL_OFF_STATUS) || (a == `ASEL_OFF_FREQ);
  endfunction

  // Terminal carries a given function code
  function automatic logic [5:0] fn_map(input logic [7:0] code, input logic [47:0] f);
    for (int i = 0; i < 6; i++) begin
      fn_map[i] = (f[i*8 +: 8] == code);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Parameter registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < 6; i++) begin
        func_q[i] <= 8'h00;
      end
      src_q     <= `ASEL_SRC_ANALOG;
      dly_en_q  <= 3'h0;
      out_req_q <= 3'h0;
      run_q     <= 1'b0;
      remote_q  <= 1'b0;
    end else if (wr) begin
      // (R20) Function assignment per terminal
      if (PADDR == `ASEL_OFF_FUNC) begin
        for (int i = 0; i < 6; i++) begin
          func_q[i] <= PWDATA[i*5 +: 5] == 5'h00 ? 8'h00 : {3'h0, PWDATA[i*5 +: 5]};
        end
      end
      if (PADDR == `ASEL_OFF_ANALOG) begin
        src_q <= PWDATA[7:0];
      end
      if (PADDR == `ASEL_OFF_DELAY) begin
        dly_en_q  <= PWDATA[2:0];
        out_req_q <= PWDATA[6:4];
      end
      if (PADDR == `ASEL_OFF_CTRL) begin
        run_q    <= PWDATA[`ASEL_CTRL_RUN];
        remote_q <= PWDATA[`ASEL_CTRL_REMOTE];
      end
    end
  end

  logic [47:0] func_flat;           // Flattened function table
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      func_flat[i*8 +: 8] = func_q[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers, two stages
  logic [5:0] pin_s1_q;             // First stage, read only by second
  logic [5:0] pin_s2_q;             // Stable terminal levels
  logic [1:0] key_s1_q;
  logic [1:0] key_s2_q;
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
      key_s1_q <= 2'h0;
      key_s2_q <= 2'h0;
    end else begin
      pin_s1_q <= INPUT_PINS;
      pin_s2_q <= pin_s1_q;
      key_s1_q <= {ANY_KEY, STOP_KEY};
      key_s2_q <= key_s1_q;
    end
  end

  // (R14) Trip reset taken as normally open only, no inversion
  logic trst_raw;                   // Any trip reset terminal high
  logic asel_lvl;                   // Any select terminal high
  logic asel_assigned;              // Select function assigned somewhere
  assign trst_raw      = |(pin_s2_q & fn_map(`ASEL_FN_TRST, func_flat));
  assign asel_lvl      = |(pin_s2_q & fn_map(`ASEL_FN_ASEL, func_flat));
  assign asel_assigned = |fn_map(`ASEL_FN_ASEL, func_flat);

  ////////////////////////////////////////////////////////////////////////
  // Frequency command selection
  asel_pkg::asel_analog_type ana;
  assign ana = '{volt: VOLT_IN, curr: CURR_IN};
  always_ff @(posedge MCLK) begin
    if (RST) begin
      FREQ_CMD <= 13'h0000;
    // (R03) Analog path only with analog source code
    end else if (src_q != `ASEL_SRC_ANALOG) begin
      FREQ_CMD <= 13'h0000;
    // (R04) Unassigned select sums both inputs
    end else if (!asel_assigned) begin
      FREQ_CMD <= {1'b0, ana.volt} + {1'b0, ana.curr};
    // (R01) Current input while select high
    end else if (asel_lvl) begin
      FREQ_CMD <= {1'b0, ana.curr};
    // (R02) Voltage input while select low
    end else begin
      FREQ_CMD <= {1'b0, ana.volt};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trip reset filter and reset sequencer
  logic [22:0] filt_q;              // Qualified width counter
  logic        trst_q;              // Filtered trip reset level
  // (R21) Ignore pulses shorter than the minimum width
  always_ff @(posedge MCLK) begin
    if (RST) begin
      filt_q <= 23'h0;
      trst_q <= 1'b0;
    end else if (!trst_raw) begin
      filt_q <= 23'h0;
      trst_q <= 1'b0;
    end else if (filt_q < 23'(TRST_MIN_CYC - 1)) begin
      filt_q <= filt_q + 23'h1;
    end else begin
      trst_q <= 1'b1;
    end
  end

  asel_pkg::asel_rst_state_type st_q;
  logic key_rst;                    // Stop key reset request
  logic key_ok;                     // Stop key usable now
  logic [26:0] pwr_q;               // Cycles since powerup, saturating
  // (R15) Powerup enters the same hold as a trip reset
  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_q <= asel_pkg::ST_HOLD;
    end else begin
      unique case (st_q)
        asel_pkg::ST_HOLD: begin
          // (R05) Release after on-off completes the reset
          if (!trst_q) begin
            st_q <= asel_pkg::ST_RUN;
          end
        end
        asel_pkg::ST_RUN: begin
          if (trst_q || key_rst) begin
            st_q <= asel_pkg::ST_HOLD;
          end
        end
        asel_pkg::ST_IDLE: begin
          st_q <= asel_pkg::ST_RUN;
        end
      endcase
    end
  end

  // (R13) Stop key resets only while alarm; (R16) remote window
  assign key_ok  = !remote_q || (pwr_q < 27'(KEYWIN_CYC));
  assign key_rst = key_s2_q[0] && trip_q && key_ok;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pwr_q <= 27'h0;
    end else if (pwr_q != 27'h7ffffff) begin
      pwr_q <= pwr_q + 27'h1;
    end
  end

  // (R08) Trip state cleared by reset; set wins over clear
  // (R07) Alarm falls two cycles after qualification, well inside 30 ms
  always_ff @(posedge MCLK) begin
    if (RST) begin
      trip_q <= 1'b0;
    end else if (wr_trip) begin
      trip_q <= 1'b1;
    end else if (st_q == asel_pkg::ST_HOLD || key_rst) begin
      trip_q <= 1'b0;
    end
  end
  assign ALARM = trip_q;

  ////////////////////////////////////////////////////////////////////////
  // Motor and logic outputs
  logic hold;                       // Reset hold active
  assign hold = (st_q == asel_pkg::ST_HOLD);
  // (R09) Motor off during hold; (R10) run resumes right after
  assign MOTOR_EN = !hold && run_q && !trip_q;
  // (R17) Reset hold releases motor to coast
  assign COAST    = hold;

  logic [26:0] odly_q [3];          // OFF delay timers
  // (R18) (R19) Outputs drop at once, or one second later if delayed
  always_ff @(posedge MCLK) begin
    if (RST) begin
      for (int i = 0; i < 3; i++) begin
        odly_q[i] <= 27'h0;
      end
      LOGIC_OUT <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!hold) begin
          odly_q[i]    <= 27'h0;
          LOGIC_OUT[i] <= out_req_q[i];
        end else if (dly_en_q[i] && LOGIC_OUT[i] && odly_q[i] < 27'(OUTDLY_CYC - 1)) begin
          odly_q[i] <= odly_q[i] + 27'h1;
        end else begin
          LOGIC_OUT[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Powerup stuck reset indication
  logic [26:0] stuck_q;             // Held-at-powerup counter
  logic        early_q;             // Reset has been high since powerup
  // (R11) Stuck beyond 4 s shows display error, no trip
  // (R12) Cleared by key once trip reset released
  always_ff @(posedge MCLK) begin
    if (RST) begin
      stuck_q     <= 27'h0;
      early_q     <= 1'b1;
      DISPLAY_ERR <= 1'b0;
    end else begin
      // Only an assigned terminal seen open proves it was never stuck
      if (!trst_raw && |fn_map(`ASEL_FN_TRST, func_flat)) begin
        early_q <= 1'b0;
      end
      if (early_q && trst_raw && stuck_q < 27'(STUCK_CYC)) begin
        stuck_q <= stuck_q + 27'h1;
      end
      if (early_q && stuck_q >= 27'(STUCK_CYC - 1)) begin
        DISPLAY_ERR <= 1'b1;
      end else if (!trst_raw && key_s2_q[1]) begin
        DISPLAY_ERR <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB read mux
  always_comb begin
    PRDATA = 32'h0;
    unique case (PADDR)
      `ASEL_OFF_CTRL:   PRDATA = {28'h0, 1'b0, remote_q, run_q, 1'b0};
      `ASEL_OFF_FUNC: begin
        for (int i = 0; i < 6; i++) begin
          PRDATA[i*5 +: 5] = func_q[i][4:0];
        end
      end
      `ASEL_OFF_ANALOG: PRDATA = {24'h0, src_q};
      `ASEL_OFF_DELAY:  PRDATA = {25'h0, out_req_q, 1'b0, dly_en_q};
      `ASEL_OFF_STATUS: PRDATA = {26'h0, DISPLAY_ERR, COAST, MOTOR_EN, hold, trst_q, trip_q};
      `ASEL_OFF_FREQ:   PRDATA = {19'h0, FREQ_CMD};
      default:          PRDATA = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  // (R09) Motor off in hold
  a_motor_off_hold: assert property (@(posedge MCLK) disable iff (RST)
    hold |-> !MOTOR_EN) else $error("motor on during reset hold"); // (R09)
  // (R17) Coast follows a qualified trip reset
  a_coast_on_hold: assert property (@(posedge MCLK) disable iff (RST)
    $rose(trst_q) |=> COAST) else $error("no coast after trip reset"); // (R17)
  // (R08) Trip cleared on reset
  a_trip_cleared: assert property (@(posedge MCLK) disable iff (RST)
    (hold && !wr_trip) |=> !ALARM) else $error("trip not cleared"); // (R08)
  // (R07) Alarm clears within two cycles of qualification
  a_alarm_clear: assert property (@(posedge MCLK) disable iff (RST)
    ($rose(trst_q) && !wr_trip) |-> ##[1:2] !ALARM) else $error("alarm late"); // (R07)
  // (R01) Current selected
  a_curr_select: assert property (@(posedge MCLK) disable iff (RST)
    (src_q == `ASEL_SRC_ANALOG && asel_assigned && asel_lvl) |=> FREQ_CMD == {1'b0, $past(CURR_IN)})
    else $error("current not selected"); // (R01)
  // (R02) Voltage selected
  a_volt_select: assert property (@(posedge MCLK) disable iff (RST)
    (src_q == `ASEL_SRC_ANALOG && asel_assigned && !asel_lvl) |=> FREQ_CMD == {1'b0, $past(VOLT_IN)})
    else $error("voltage not selected"); // (R02)
  // (R03) Non-analog source gives zero
  a_src_gate: assert property (@(posedge MCLK) disable iff (RST)
    (src_q != `ASEL_SRC_ANALOG) |=> FREQ_CMD == 13'h0) else $error("analog used wrongly"); // (R03)
  // (R21) Short pulses ignored
  sequence s_short_pulse;
    !trst_raw ##1 trst_raw ##1 !trst_raw;
  endsequence
  a_filter_short: assert property (@(posedge MCLK) disable iff (RST)
    s_short_pulse |-> !trst_q) else $error("short pulse passed filter"); // (R21)
  // (R18) Undelayed outputs drop at once
  a_out_drop: assert property (@(posedge MCLK) disable iff (RST)
    (hold && dly_en_q == 3'h0) |=> LOGIC_OUT == 3'h0) else $error("outputs not off"); // (R18)
endmodule

/* logic/asel_consts.svh */
// Constants for the analog source select and trip reset block
`ifndef ASEL_CONSTS_SVH
`define ASEL_CONSTS_SVH
// Register byte offsets
`define ASEL_OFF_CTRL     12'h000
`define ASEL_OFF_FUNC     12'h004
`define ASEL_OFF_ANALOG   12'h008
`define ASEL_OFF_DELAY    12'h00c
`define ASEL_OFF_STATUS   12'h010
`define ASEL_OFF_FREQ     12'h014
// Input function codes
`define ASEL_FN_ASEL      8'h10
`define ASEL_FN_TRST      8'h12
// Frequency source code for analog terminals
`define ASEL_SRC_ANALOG   8'h01
// Timing, in their own units
`define ASEL_CLK_HZ       25000000
`define ASEL_TRST_MIN_MS  12
`define ASEL_ALARM_MS     30
`define ASEL_STUCK_MS     4000
`define ASEL_OUTDLY_MS    1000
`define ASEL_KEYWIN_MS    3000
// Cycle counts; truncating integer division, exact at 25 MHz
`define ASEL_TRST_MIN_CYC ((`ASEL_CLK_HZ / 1000 * `ASEL_TRST_MIN_MS) )
`define ASEL_STUCK_CYC    ((`ASEL_CLK_HZ / 1000) * `ASEL_STUCK_MS)
`define ASEL_OUTDLY_CYC   ((`ASEL_CLK_HZ / 1000) * `ASEL_OUTDLY_MS)
`define ASEL_KEYWIN_CYC   ((`ASEL_CLK_HZ / 1000) * `ASEL_KEYWIN_MS)
// Control register field positions
`define ASEL_CTRL_TRIP    0
`define ASEL_CTRL_RUN     1
`define ASEL_CTRL_REMOTE  2
`define ASEL_CTRL_KEY     3
`endif

/* logic/asel_pkg.sv */
// Types for the analog source select and trip reset block
package asel_pkg;
  // Reset sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RUN} asel_rst_state_type;
  // Analog sample pair
  typedef struct packed {
    logic [11:0] volt;
    logic [11:0] curr;
  } asel_analog_type;
endpackage

/* verif/asel_contact.sv */
// External contact model that closes the trip reset terminal for a set time
`timescale 1ns/1ps
module asel_contact (
  // Clock and command from the bench
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  // Contact level at the terminal
  output logic            pin
);
  logic [7:0] cnt_q = 8'h00;  // Cycles left closed
  ////////////////////////////////////////////////////////////////
  // pulse width held
  always_ff @(posedge mclk) begin
    if (go) begin
      cnt_q <= len;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Open contact is pulled low, so no stale level is left behind
  assign pin = (cnt_q != 8'h00);
endmodule

/* verif/asel_top_test.sv */
// Self-checking bench for the analog select and trip reset block
`timescale 1ns/1ps
`include "asel_consts.svh"
module asel_top_test;
  localparam int TMIN = 4;   // Shortened filter span
  localparam int ODLY = 10;  // Shortened output off delay
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, MOTOR_EN, COAST, ALARM, DISPLAY_ERR;
  logic        STOP_KEY = 1'b0;
  logic        ANY_KEY = 1'b0;
  logic [4:0]  pins_lo = 5'h00;   // Bench terminals, select on bit 2
  logic [11:0] VOLT_IN = 12'h000;
  logic [11:0] CURR_IN = 12'h000;
  logic [2:0]  LOGIC_OUT;
  logic [12:0] FREQ_CMD;
  logic        go = 1'b0;
  logic [7:0]  len = 8'h00;
  logic        trst_pin;          // Terminal 5 carries trip reset
  logic [31:0] rnd = 32'hfd89c880;
  logic [31:0] rd;
  logic        err, hit;
  int          bad_count = 0;
  int          n_compared = 0;

  // Clock at 25 MHz
  always #20 MCLK = ~MCLK;

  asel_top #(.TRST_MIN_CYC(TMIN), .STUCK_CYC(50), .OUTDLY_CYC(ODLY), .KEYWIN_CYC(20)) dut (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INPUT_PINS({trst_pin, pins_lo}), .STOP_KEY(STOP_KEY), .ANY_KEY(ANY_KEY),
    .VOLT_IN(VOLT_IN), .CURR_IN(CURR_IN), .MOTOR_EN(MOTOR_EN), .COAST(COAST),
    .ALARM(ALARM), .LOGIC_OUT(LOGIC_OUT), .DISPLAY_ERR(DISPLAY_ERR), .FREQ_CMD(FREQ_CMD));

  asel_contact contact (.mclk(MCLK), .go(go), .len(len), .pin(trst_pin));

  ////////////////////////////////////////////////////////////////
  // Next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected frequency command
  function automatic logic [31:0] exp_freq(input logic [7:0] src, input logic asgn, sel,
                                           input logic [11:0] v, c);
    if (src != `ASEL_SRC_ANALOG) return 32'h0;
    if (!asgn) return {20'h0, v} + {20'h0, c};
    return sel ? {20'h0, c} : {20'h0, v};
  endfunction

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  // One APB transfer; waits on pready, no assumed latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Random analog samples, then compare the command
  task automatic freq_case(input logic [7:0] src, input logic asgn, sel);
    rnd = lfsr(rnd);
    @(posedge MCLK);
    VOLT_IN <= rnd[11:0];
    CURR_IN <= rnd[27:16];
    pins_lo[2] <= sel;
    cyc(5);  // Two sync stages plus the output register
    chk("freq", FREQ_CMD, exp_freq(src, asgn, sel, rnd[11:0], rnd[27:16]));
  endtask

  // Ask the contact for a closure of n cycles
  task automatic pulse(input logic [7:0] n);
    @(posedge MCLK);
    go <= 1'b1;
    len <= n;
    @(posedge MCLK);
    go <= 1'b0;
  endtask

  // Press stop key, note any reset hold
  task automatic press;
    @(posedge MCLK);
    STOP_KEY <= 1'b1;
    hit = 1'b0;
    repeat (6) begin
      @(posedge MCLK);
      hit = hit | COAST;
    end
    STOP_KEY <= 1'b0;
    cyc(4);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Watchdog, well beyond the five hundred or so cycles needed
  initial begin
    cyc(5000);
    bad_count++;
    end_of_test();
  end

  initial begin
    cyc(7);
    chk("coast_in_reset", COAST, 1);
    @(posedge MCLK);
    RST <= 1'b0;
    cyc(8);
    chk("coast_after_reset", COAST, 0);
    apb(1'b0, `ASEL_OFF_ANALOG, 32'h0);
    chk("source_reset", rd, 32'h1);
    // Unmapped place is refused
    apb(1'b1, 12'h020, 32'hffffffff);
    chk("unmapped_err", err, 1);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_read", rd, 32'h0);
    // Trip reset on terminal 5 only, select unassigned
    apb(1'b1, `ASEL_OFF_FUNC, 32'h24000000);
    repeat (4) freq_case(8'h01, 1'b0, rnd[0]);
    // Corner: next word gives full-scale samples, the sum needs all 13 bits
    rnd = 32'h07ff87ff;
    freq_case(8'h01, 1'b0, 1'b0);
    // Select on terminal 2 as well
    apb(1'b1, `ASEL_OFF_FUNC, 32'h24004000);
    for (int i = 0; i < 8; i++) freq_case(8'h01, 1'b1, i[0]);
    apb(1'b1, `ASEL_OFF_ANALOG, 32'h2);
    repeat (2) freq_case(8'h02, 1'b1, 1'b1);
    apb(1'b1, `ASEL_OFF_ANALOG, 32'h1);
    // Trip while running, then two too short closures
    apb(1'b1, `ASEL_OFF_CTRL, 32'h3);
    cyc(2);
    chk("alarm_set", ALARM, 1);
    pulse(8'd1);
    pulse(8'd2);
    cyc(TMIN + 8);
    chk("short_pulse_alarm", ALARM, 1);
    chk("short_pulse_hold", COAST, 0);
    // Proper closure resets while held
    pulse(8'd12);
    cyc(TMIN + 6);
    chk("hold_coast", COAST, 1);
    chk("hold_motor", MOTOR_EN, 0);
    chk("alarm_cleared", ALARM, 0);
    cyc(14);
    chk("release_coast", COAST, 0);
    chk("motor_resumes", MOTOR_EN, 1);
    // Output 0 delayed, output 1 not
    apb(1'b1, `ASEL_OFF_DELAY, 32'h31);
    cyc(3);
    chk("outs_on", LOGIC_OUT, 3'b011);
    pulse(8'd40);
    cyc(TMIN + 6);
    chk("outs_delayed", LOGIC_OUT, 3'b001);
    chk("motor_off", MOTOR_EN, 0);
    cyc(ODLY + 4);
    chk("outs_off", LOGIC_OUT, 3'b000);
    cyc(40);
    // Stop key without alarm does nothing
    apb(1'b1, `ASEL_OFF_CTRL, 32'h2);
    press();
    chk("key_no_alarm", hit, 0);
    // Remote attached, window long gone: key ignored
    apb(1'b1, `ASEL_OFF_CTRL, 32'h7);
    press();
    chk("key_remote", ALARM, 1);
    apb(1'b1, `ASEL_OFF_CTRL, 32'h3);
    press();
    chk("key_alarm", ALARM, 0);
    // Mid-run reset with the contact closed through powerup
    @(posedge MCLK);
    RST <= 1'b1;
    pulse(8'd200);
    cyc(6);
    chk("coast_mid_reset", COAST, 1);
    RST <= 1'b0;
    // Remote attached, still inside the key window: key resets
    apb(1'b1, `ASEL_OFF_CTRL, 32'h5);
    press();
    chk("key_window_hold", hit, 1);
    chk("key_window", ALARM, 0);
    // Assign trip reset while the terminal is still stuck closed
    apb(1'b1, `ASEL_OFF_FUNC, 32'h24000000);
    cyc(60);
    chk("stuck_display", DISPLAY_ERR, 1);
    chk("stuck_no_trip", ALARM, 0);
    // Contact opens, indication stays until a key is pressed
    cyc(140);
    chk("release_no_clear", DISPLAY_ERR, 1);
    @(posedge MCLK);
    ANY_KEY <= 1'b1;
    cyc(4);
    ANY_KEY <= 1'b0;
    chk("key_clears_display", DISPLAY_ERR, 0);
    end_of_test();
  end
endmodule
